// ===== core/bus_matrix_four_by_five.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// - Four masters may each run a transfer at once as long as each targets a free slave.
// - Every master port has its own address decoder and all decode addresses identically.
// - Masters are 0 cpu instr/data, 1 cpu system, 2 peripheral dma, 3 crc calculator.
// - Five slave ports each have an independent arbiter whose scheme may differ per slave.
// - Slaves are 0 sram, 1 rom, 2 flash, 3 external bus interface, 4 peripheral bridge.
// - Cpu instr/data reaches only rom and flash; cpu system only sram, ext bus and bridge.
// - Dma reaches all but flash; crc calculator reaches all but the peripheral bridge.
// - A path missing from the connectivity map can carry no transfer.
// - Peripherals behind the bridge run on the master clock that drives the matrix.
module bus_matrix_four_by_five #(
   parameter logic [bus_matrix_pkg::NUM_SLAVES-1:0] SLAVE_ROUND_ROBIN = 5'h00
) (
   // master clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // master ports
   input wire logic [bus_matrix_pkg::NUM_MASTERS-1:0] m_req_i,
   input wire logic [bus_matrix_pkg::NUM_MASTERS-1:0][bus_matrix_pkg::ADDR_W-1:0] m_addr_i,
   input wire logic [bus_matrix_pkg::NUM_MASTERS-1:0] m_write_i,
   input wire logic [bus_matrix_pkg::NUM_MASTERS-1:0][bus_matrix_pkg::DATA_W-1:0] m_wdata_i,
   output logic [bus_matrix_pkg::NUM_MASTERS-1:0] m_done_o,
   output logic [bus_matrix_pkg::NUM_MASTERS-1:0] m_err_o,
   output logic [bus_matrix_pkg::NUM_MASTERS-1:0][bus_matrix_pkg::DATA_W-1:0] m_rdata_o,
   // slave ports
   output logic [bus_matrix_pkg::NUM_SLAVES-1:0] s_sel_o,
   output logic [bus_matrix_pkg::NUM_SLAVES-1:0][bus_matrix_pkg::ADDR_W-1:0] s_addr_o,
   output logic [bus_matrix_pkg::NUM_SLAVES-1:0] s_write_o,
   output logic [bus_matrix_pkg::NUM_SLAVES-1:0][bus_matrix_pkg::DATA_W-1:0] s_wdata_o,
   input wire logic [bus_matrix_pkg::NUM_SLAVES-1:0] s_ready_i,
   input wire logic [bus_matrix_pkg::NUM_SLAVES-1:0][bus_matrix_pkg::DATA_W-1:0] s_rdata_i
);

   localparam int NM = bus_matrix_pkg::NUM_MASTERS;
   localparam int NS = bus_matrix_pkg::NUM_SLAVES;

   logic [NM-1:0] active;
   logic [NM-1:0] pend;
   logic [NM-1:0][NS-1:0] hit;
   logic [NM-1:0] legal;
   logic [NS-1:0][NM-1:0] arb_req;
   logic [NS-1:0][NM-1:0] grant;
   logic [NS-1:0][NM-1:0] owner;
   logic [NS-1:0] busy;
   logic [NS-1:0] finish;
   logic [NM-1:0] served;
   logic [NM-1:0][bus_matrix_pkg::DATA_W-1:0] served_data;

   // ------------------------------------------------------------
   // per-master decoders
   // ------------------------------------------------------------
   // a master waiting for an answer, not yet served, not in its done cycle
   assign pend = m_req_i & ~active & ~m_done_o;

   always_comb
   begin
      for (int m = 0; m < NM; m++)
      begin
         // same shared decode function for every master
         hit[m] = bus_matrix_pkg::decode(m_addr_i[m]);
         // index m follows the fixed master numbering
         legal[m] = |(hit[m] & bus_matrix_pkg::PATH_OK[m]);
      end
   end

   // ------------------------------------------------------------
   // request routing to the slave arbiters
   // ------------------------------------------------------------
   always_comb
   begin
      for (int s = 0; s < NS; s++)
      begin
         for (int m = 0; m < NM; m++)
         begin
            // unwired paths never reach an arbiter
            arb_req[s][m] = pend[m] & hit[m][s] & bus_matrix_pkg::PATH_OK[m][s];
         end
         finish[s] = busy[s] & s_sel_o[s] & s_ready_i[s];
      end
   end

   // ------------------------------------------------------------
   // one arbiter per slave
   // ------------------------------------------------------------
   for (genvar s = 0; s < NS; s++)
   begin : g_arb
      // scheme chosen per slave
      slave_arbiter #(
         .NUM_REQ(NM),
         .ROUND_ROBIN(SLAVE_ROUND_ROBIN[s])
      ) u_arb (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .req_i(arb_req[s]),
         .done_i(finish[s]),
         .grant_o(grant[s]),
         .owner_o(owner[s]),
         .busy_o(busy[s])
      );
   end

   // ------------------------------------------------------------
   // slave side: request forwarded from the granted master
   // ------------------------------------------------------------
   // slave index s follows the fixed slave numbering; the bridge port
   // toggles on clk_i like every other slave port
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_sel_o <= '0;
         s_addr_o <= '0;
         s_write_o <= '0;
         s_wdata_o <= '0;
      end
      else
      begin
         for (int s = 0; s < NS; s++)
         begin
            if (finish[s])
            begin
               s_sel_o[s] <= 1'b0;
            end
            for (int m = 0; m < NM; m++)
            begin
               if (grant[s][m])
               begin
                  s_sel_o[s] <= 1'b1;
                  s_addr_o[s] <= m_addr_i[m];
                  s_write_o[s] <= m_write_i[m];
                  s_wdata_o[s] <= m_wdata_i[m];
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // master side: in-flight tracking
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         active <= '0;
      end
      else
      begin
         for (int m = 0; m < NM; m++)
         begin
            for (int s = 0; s < NS; s++)
            begin
               if (finish[s] && owner[s][m])
               begin
                  active[m] <= 1'b0;
               end
               if (grant[s][m])
               begin
                  active[m] <= 1'b1;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // master side: completion routed back from the owning slave
   // ------------------------------------------------------------
   always_comb
   begin
      served = '0;
      served_data = '0;
      for (int m = 0; m < NM; m++)
      begin
         for (int s = 0; s < NS; s++)
         begin
            // a master owns one slave at most, so or-ing the data is safe
            if (finish[s] && owner[s][m])
            begin
               served[m] = 1'b1;
               served_data[m] = served_data[m] | s_rdata_i[s];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // master side: answers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         m_done_o <= '0;
         m_err_o <= '0;
         m_rdata_o <= '0;
      end
      else
      begin
         for (int m = 0; m < NM; m++)
         begin
            m_done_o[m] <= 1'b0;
            m_err_o[m] <= 1'b0;
            // unmapped address or forbidden path ends at once with error
            if (pend[m] && !legal[m])
            begin
               m_done_o[m] <= 1'b1;
               m_err_o[m] <= 1'b1;
            end
            if (served[m])
            begin
               m_done_o[m] <= 1'b1;
               m_rdata_o[m] <= served_data[m];
            end
         end
      end
   end

endmodule : bus_matrix_four_by_five

`default_nettype wire

// ===== core/bus_matrix_pkg.sv
package bus_matrix_pkg;

   // ------------------------------------------------------------
   // port counts and widths
   // ------------------------------------------------------------
   localparam int NUM_MASTERS = 4;
   localparam int NUM_SLAVES = 5;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------
   // master numbering
   // ------------------------------------------------------------
   localparam int M_CPU_INSTR_DATA = 0;
   localparam int M_CPU_SYSTEM = 1;
   localparam int M_PERIPHERAL_DMA = 2;
   localparam int M_CRC_CALC = 3;

   // ------------------------------------------------------------
   // slave numbering
   // ------------------------------------------------------------
   localparam int S_SRAM = 0;
   localparam int S_ROM = 1;
   localparam int S_FLASH = 2;
   localparam int S_EXT_BUS = 3;
   localparam int S_PERIPH_BRIDGE = 4;

   // ------------------------------------------------------------
   // address map, shared by every master decoder
   // ------------------------------------------------------------
   localparam logic [NUM_SLAVES-1:0][ADDR_W-1:0] SLAVE_BASE = {
      32'h6000_0000,   // peripheral bridge
      32'h4000_0000,   // external bus
      32'h0040_0000,
      32'h0080_0000,
      32'h2000_0000};
   localparam logic [NUM_SLAVES-1:0][ADDR_W-1:0] SLAVE_MASK = {
      32'he000_0000,
      32'he000_0000,
      32'hffe0_0000,
      32'hffc0_0000,
      32'he000_0000};

   // ------------------------------------------------------------
   // connectivity map, one bit per slave, index = master
   // ------------------------------------------------------------
   localparam logic [NUM_MASTERS-1:0][NUM_SLAVES-1:0] PATH_OK = {
      5'h0f,   // crc: sram, rom, flash, ext bus
      5'h1b,   // dma: sram, rom, ext bus, bridge
      5'h19,   // cpu system: sram, ext bus, bridge
      5'h06};  // cpu instr/data: rom, flash

   // ------------------------------------------------------------
   // arbiter states
   // ------------------------------------------------------------
   typedef enum logic {
      ARB_IDLE = 1'b0,
      ARB_BUSY = 1'b1
   } arb_state_t;

   // one-hot slave hit for an address
   function automatic logic [NUM_SLAVES-1:0] decode(input logic [ADDR_W-1:0] addr);
      logic [NUM_SLAVES-1:0] hit;
      hit = '0;
      for (int s = 0; s < NUM_SLAVES; s++)
      begin
         hit[s] = ((addr & SLAVE_MASK[s]) == SLAVE_BASE[s]);
      end
      return hit;
   endfunction : decode

endpackage : bus_matrix_pkg

// ===== core/slave_arbiter.sv
`timescale 1ns/10ps
`default_nettype none

module slave_arbiter #(
   parameter int NUM_REQ = 4,
   parameter bit ROUND_ROBIN = 1'b0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // requests and completion
   input wire logic [NUM_REQ-1:0] req_i,
   input wire logic done_i,
   // grant
   output logic [NUM_REQ-1:0] grant_o,
   output logic [NUM_REQ-1:0] owner_o,
   output logic busy_o
);

   bus_matrix_pkg::arb_state_t state;
   logic [NUM_REQ-1:0] owner;
   logic [NUM_REQ-1:0] last;
   logic [NUM_REQ-1:0] winner;

   // ------------------------------------------------------------
   // winner selection: fixed low-index first, or rotating
   // ------------------------------------------------------------
   always_comb
   begin
      int idx;
      winner = '0;
      idx = 0;
      for (int k = NUM_REQ - 1; k >= 0; k--)
      begin
         if (ROUND_ROBIN)
         begin
            idx = 0;
            for (int j = 0; j < NUM_REQ; j++)
            begin
               if (last[j])
               begin
                  idx = j;
               end
            end
            idx = (idx + 1 + k) % NUM_REQ;
         end
         else
         begin
            idx = k;
         end
         if (req_i[idx])
         begin
            winner = '0;
            winner[idx] = 1'b1;
         end
      end
   end

   // only one grant while idle
   assign grant_o = (state == bus_matrix_pkg::ARB_IDLE) ? winner : '0;
   assign owner_o = owner;
   assign busy_o = (state == bus_matrix_pkg::ARB_BUSY);

   // ------------------------------------------------------------
   // ownership held until the transfer completes
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= bus_matrix_pkg::ARB_IDLE;
         owner <= '0;
         last <= '0;
      end
      else
      begin
         case (state)
            bus_matrix_pkg::ARB_IDLE:
            begin
               if (|winner)
               begin
                  state <= bus_matrix_pkg::ARB_BUSY;
                  owner <= winner;
                  last <= winner;
               end
            end
            bus_matrix_pkg::ARB_BUSY:
            begin
               if (done_i)
               begin
                  state <= bus_matrix_pkg::ARB_IDLE;
                  owner <= '0;
               end
            end
            default:
            begin
               state <= bus_matrix_pkg::ARB_IDLE;
               owner <= '0;
            end
         endcase
      end
   end

endmodule : slave_arbiter

`default_nettype wire

// ===== tb/bus_matrix_sva.sv
`timescale 1ns/10ps
`default_nettype none
module bus_matrix_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] m_req_i,
   input wire logic [3:0][31:0] m_addr_i,
   input wire logic [3:0] m_done_o,
   input wire logic [3:0] m_err_o,
   input wire logic [4:0] s_sel_o,
   input wire logic [4:0][31:0] s_addr_o,
   input wire logic [4:0] s_ready_i
);
   localparam logic [3:0][4:0] LEGAL = {5'h0f, 5'h1b, 5'h19, 5'h06};
   logic [3:0] ok;
   always_comb
   begin
      ok = '0;
      for (int m = 0; m < 4; m++)
      begin
         for (int s = 0; s < 5; s++)
         begin
            if (((m_addr_i[m] & bus_matrix_pkg::SLAVE_MASK[s]) == bus_matrix_pkg::SLAVE_BASE[s])
               && LEGAL[m][s])
            begin
               ok[m] = 1'b1;
            end
         end
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence taken(int s);
      s_sel_o[s] && s_ready_i[s];
   endsequence
   for (genvar m = 0; m < 4; m++)
   begin : g_m
      done_pulse_a: assert property (m_done_o[m] |=> !m_done_o[m])
         else $error("done held too long");
      err_done_a: assert property (m_err_o[m] |-> m_done_o[m])
         else $error("error without done");
      bad_path_a: assert property ($rose(m_req_i[m]) && !ok[m] |=> m_done_o[m] && m_err_o[m])
         else $error("forbidden path not refused");
      legal_wait_a: assert property ($rose(m_req_i[m]) && ok[m] |=> !m_done_o[m])
         else $error("legal transfer ended too soon");
      path_ok_a: assert property (m_done_o[m] && !m_err_o[m] |-> ok[m])
         else $error("transfer passed on a missing path");
   end
   for (genvar s = 0; s < 5; s++)
   begin : g_s
      sel_hold_a: assert property (s_sel_o[s] && !s_ready_i[s] |=> s_sel_o[s] && $stable(s_addr_o[s]))
         else $error("select dropped early");
      sel_drop_a: assert property (taken(s) |=> !s_sel_o[s])
         else $error("select held after ready");
      sel_addr_a: assert property (s_sel_o[s] |->
         (s_addr_o[s] & bus_matrix_pkg::SLAVE_MASK[s]) == bus_matrix_pkg::SLAVE_BASE[s])
         else $error("slave address outside its range");
      done_after_a: assert property (taken(s) |=> |m_done_o)
         else $error("no completion after ready");
   end
endmodule : bus_matrix_sva
bind bus_matrix_four_by_five bus_matrix_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .m_req_i(m_req_i), .m_addr_i(m_addr_i), .m_done_o(m_done_o), .m_err_o(m_err_o),
   .s_sel_o(s_sel_o), .s_addr_o(s_addr_o), .s_ready_i(s_ready_i));
`default_nettype wire

// ===== tb/slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module slave_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] sel_i,
   input wire logic [4:0][31:0] addr_i,
   input wire logic [4:0] write_i,
   input wire logic [4:0][31:0] wdata_i,
   input wire logic [3:0] wait_i,
   output logic [4:0] ready_o,
   output logic [4:0][31:0] rdata_o
);
   logic [4:0][3:0] cnt;
   logic [4:0][31:0] mem;
   always_comb
   begin
      for (int s = 0; s < 5; s++)
      begin
         ready_o[s] = sel_i[s] && (cnt[s] == wait_i);
         // outside ready the data lines show the inverse
         rdata_o[s] = ready_o[s] ? addr_i[s] ^ 32'h5a5a_5a5a : ~(addr_i[s] ^ 32'h5a5a_5a5a);
      end
   end
   always_ff @(posedge clk_i)
   begin
      for (int s = 0; s < 5; s++)
      begin
         cnt[s] <= (rst_i || !sel_i[s] || ready_o[s]) ? 4'h0 : cnt[s] + 4'h1;
         if (ready_o[s] && write_i[s])
         begin
            mem[s] <= wdata_i[s];
         end
      end
   end
endmodule : slave_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam logic [3:0][4:0] LEGAL = {5'h0f, 5'h1b, 5'h19, 5'h06};
   logic clk_i, rst_i;
   logic [3:0] m_req_i, m_write_i, m_done_o, m_err_o, wait_c;
   logic [3:0][31:0] m_addr_i, m_wdata_i, m_rdata_o;
   logic [4:0] s_sel_o, s_write_o, s_ready_i;
   logic [4:0][31:0] s_addr_o, s_wdata_o, s_rdata_i;
   int bad_count, total_checks;
   int cyc = 0;
   int t[4];
   bus_matrix_four_by_five #(.SLAVE_ROUND_ROBIN(5'h08)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .m_req_i(m_req_i), .m_addr_i(m_addr_i), .m_write_i(m_write_i), .m_wdata_i(m_wdata_i),
      .m_done_o(m_done_o),
      .m_err_o(m_err_o), .m_rdata_o(m_rdata_o), .s_sel_o(s_sel_o), .s_addr_o(s_addr_o),
      .s_write_o(s_write_o), .s_wdata_o(s_wdata_o), .s_ready_i(s_ready_i),
      .s_rdata_i(s_rdata_i));
   slave_model u_slv (.clk_i(clk_i), .rst_i(rst_i), .sel_i(s_sel_o), .addr_i(s_addr_o),
      .write_i(s_write_o), .wdata_i(s_wdata_o), .wait_i(wait_c), .ready_o(s_ready_i),
      .rdata_o(s_rdata_i));
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cyc <= cyc + 1;
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   task automatic xfer(input int m, input int s, input logic [31:0] a, input logic w,
      input logic e);
      int n;
      m_addr_i[m] = a;
      m_write_i[m] = w;
      m_wdata_i[m] = ~a;
      m_req_i[m] = 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      while (m_done_o[m] !== 1'b1 && n < 40);
      if (m_done_o[m] !== 1'b1)
      begin
         check("done", 32'h1, 32'h0);
         final_report();
      end
      t[m] = cyc;
      check("err", {31'h0, e}, {31'h0, m_err_o[m]});
      if (!e && !w)
         check("rdata", a ^ 32'h5a5a_5a5a, m_rdata_o[m]);
      m_req_i[m] = 1'b0;
      @(posedge clk_i);
      #1;
      if (!e && w)
         check("wdata", ~a, u_slv.mem[s]);
   endtask : xfer
   task automatic test_map;
      for (int m = 0; m < 4; m++)
         for (int s = 0; s < 5; s++)
            xfer(m, s, bus_matrix_pkg::SLAVE_BASE[s] + 32'h40, 1'((m + s) % 2), !LEGAL[m][s]);
      for (int m = 0; m < 4; m++)
         xfer(m, 0, 32'h0000_0000, 1'(m % 2), 1'b1);
      $display("test_map done");
   endtask : test_map
   task automatic test_concurrent;
      wait_c = 4'h2;
      fork
         xfer(0, 1, bus_matrix_pkg::SLAVE_BASE[1], 1'b0, 1'b0);
         xfer(1, 0, bus_matrix_pkg::SLAVE_BASE[0], 1'b1, 1'b0);
         xfer(2, 4, bus_matrix_pkg::SLAVE_BASE[4], 1'b0, 1'b0);
         xfer(3, 2, bus_matrix_pkg::SLAVE_BASE[2], 1'b0, 1'b0);
      join
      for (int m = 1; m < 4; m++)
         check("parallel", 32'(t[0]), 32'(t[m]));
      $display("test_concurrent done");
   endtask : test_concurrent
   task automatic test_contend;
      wait_c = 4'h3;
      fork
         xfer(3, 0, bus_matrix_pkg::SLAVE_BASE[0] + 32'h8, 1'b0, 1'b0);
         xfer(2, 0, bus_matrix_pkg::SLAVE_BASE[0] + 32'h4, 1'b0, 1'b0);
         xfer(1, 0, bus_matrix_pkg::SLAVE_BASE[0], 1'b1, 1'b0);
      join
      check("order", 32'h1, {31'h0, t[1] < t[2] && t[2] < t[3]});
      $display("test_contend done");
   endtask : test_contend
   task automatic test_rotate;
      wait_c = 4'h1;
      xfer(1, 3, bus_matrix_pkg::SLAVE_BASE[3] + 32'h10, 1'b1, 1'b0);
      fork
         xfer(1, 3, bus_matrix_pkg::SLAVE_BASE[3] + 32'h20, 1'b0, 1'b0);
         xfer(2, 3, bus_matrix_pkg::SLAVE_BASE[3] + 32'h24, 1'b0, 1'b0);
         xfer(3, 3, bus_matrix_pkg::SLAVE_BASE[3] + 32'h28, 1'b0, 1'b0);
      join
      check("rotate", 32'h1, {31'h0, t[2] < t[3] && t[3] < t[1]});
      $display("test_rotate done");
   endtask : test_rotate
   initial
   begin
      bad_count = 0;
      total_checks = 0;
      rst_i = 1'b1;
      m_req_i = '0;
      m_write_i = '0;
      m_addr_i = '0;
      m_wdata_i = '0;
      wait_c = 4'h0;
      repeat (5) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      @(posedge clk_i);
      #1;
      test_map();
      test_concurrent();
      test_contend();
      test_rotate();
      final_report();
   end
endmodule : testbench
`default_nettype wire
